// file: core/brake_sequencer_pwm.v
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`include "brake_sequencer_pwm_defs.vh"
`default_nettype none
// Operation
// - on an enable request the motor current goes on first, then the pre-release delay elapses.
// - after that delay the brake releases, the post-release delay elapses, then the enabled state is reported.
// - on a request to leave the enabled state the motor is brought to standstill, then the pre-engage delay elapses.
// - then the brake engages, the post-engage delay elapses, and the motor current is switched off.
// - while released in automatic mode, the brake output is a PWM signal with configurable frequency and duty cycle.
// - the PWM frequency is given in hertz and settings above 2000 are refused.
// - the duty setting is a percentage accepted only from 2 to 100.
// - a duty of 100 holds the brake output continuously on.
// - high time is the duty percentage of a period that does not depend on the duty.
// - sequences start only with the automatic bit set; clearing it runs the engage sequence to the off state, then the manual bit drives the brake.
// - in automatic mode the brake stays engaged outside the enabled sequence.
module brake_sequencer_pwm #(
  parameter integer TICK_CYCLES = (`CLK_HZ / 1000000) * `DELAY_UNIT_US,
  parameter integer DELAY_W = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire enable_req,
  input wire standstill,
  output reg motor_current_on,
  output reg halt_req,
  output reg brake_out,
  output reg op_enabled
);
  localparam [2:0] ST_OFF = 3'd0;
  localparam [2:0] ST_PRE_REL = 3'd1;
  localparam [2:0] ST_POST_REL = 3'd2;
  localparam [2:0] ST_ENABLED = 3'd3;
  localparam [2:0] ST_STOP = 3'd4;
  localparam [2:0] ST_PRE_ENG = 3'd5;
  localparam [2:0] ST_POST_ENG = 3'd6;
  localparam [27:0] CLK_HZ_W = `CLK_HZ;
  localparam [31:0] CTRL_RST_W = `CTRL_RST;
  localparam [0:0] AUTO_RST = CTRL_RST_W[`CTRL_AUTO_BIT];

  reg auto_r, manual_r;
  reg [DELAY_W-1:0] pre_rel_r, post_rel_r, pre_eng_r, post_eng_r;
  reg [10:0] freq_r;
  reg [6:0] duty_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  reg [2:0] state_r, state_nxt;
  reg [DELAY_W:0] wait_r; // one spare bit so a full-scale delay can still be exceeded
  reg [31:0] tick_cnt_r;
  reg tick_r;
  reg [27:0] acc_r;
  reg [6:0] step_r;
  reg pwm_r;
  reg still_m_r, still_r;
  wire accept;
  wire wait_done;
  reg [DELAY_W-1:0] delay_sel;

  function [31:0] read_mux;
    input [7:0] a;
    begin
      case (a)
        `OFS_CTRL: read_mux = {29'h0, auto_r, 1'b0, manual_r};
        `OFS_PRE_REL: read_mux = {{(32-DELAY_W){1'b0}}, pre_rel_r};
        `OFS_POST_REL: read_mux = {{(32-DELAY_W){1'b0}}, post_rel_r};
        `OFS_PRE_ENG: read_mux = {{(32-DELAY_W){1'b0}}, pre_eng_r};
        `OFS_POST_ENG: read_mux = {{(32-DELAY_W){1'b0}}, post_eng_r};
        `OFS_PWM_FREQ: read_mux = {21'h0, freq_r};
        `OFS_PWM_DUTY: read_mux = {25'h0, duty_r};
        `OFS_STATUS: read_mux = {25'h0, still_r, op_enabled, brake_out, state_r, 1'b0};
        default: read_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  // zero-wait slave: address phase latched, write lands in the data phase
  assign accept = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0; // always OKAY, unmapped reads give zero
      wr_pend_r <= accept & hwrite;
      if (accept) begin
        wr_addr_r <= haddr;
        hrdata <= read_mux(haddr);
      end
    end
  end

  // register writes; out-of-range frequency or duty is dropped, old value kept
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_r <= AUTO_RST;
      manual_r <= 1'b0;
      pre_rel_r <= `DELAY_RST;
      post_rel_r <= `DELAY_RST;
      pre_eng_r <= `DELAY_RST;
      post_eng_r <= `DELAY_RST;
      freq_r <= `FREQ_RST;
      duty_r <= `DUTY_RST;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        `OFS_CTRL: begin
          auto_r <= hwdata[`CTRL_AUTO_BIT];
          manual_r <= hwdata[`CTRL_MANUAL_BIT];
        end
        `OFS_PRE_REL: pre_rel_r <= hwdata[DELAY_W-1:0];
        `OFS_POST_REL: post_rel_r <= hwdata[DELAY_W-1:0];
        `OFS_PRE_ENG: pre_eng_r <= hwdata[DELAY_W-1:0];
        `OFS_POST_ENG: post_eng_r <= hwdata[DELAY_W-1:0];
        `OFS_PWM_FREQ: begin
          if (hwdata[31:11] == 21'h0 && hwdata[10:0] != 11'h0 && hwdata[10:0] <= `FREQ_MAX)
            freq_r <= hwdata[10:0];
        end
        `OFS_PWM_DUTY: begin
          if (hwdata[31:7] == 25'h0 && hwdata[6:0] >= `DUTY_MIN && hwdata[6:0] <= `DUTY_MAX)
            duty_r <= hwdata[6:0];
        end
        default: ;
      endcase
    end
  end

  // standstill comes from the power stage, so it is synchronised first
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      still_m_r <= 1'b0;
      still_r <= 1'b0;
    end else begin
      still_m_r <= standstill;
      still_r <= still_m_r;
    end
  end

  // delay time base: one enable pulse per delay unit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TICK_CYCLES - 1);
      tick_cnt_r <= (tick_cnt_r == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end

  always @* begin
    case (state_r)
      ST_PRE_REL: delay_sel = pre_rel_r;
      ST_POST_REL: delay_sel = post_rel_r;
      ST_PRE_ENG: delay_sel = pre_eng_r;
      ST_POST_ENG: delay_sel = post_eng_r;
      default: delay_sel = {DELAY_W{1'b0}};
    endcase
  end
  // tick phase is free-running, so count one tick past the setting: a wait of n units lasts n to n+1 units,
  // never less than programmed
  assign wait_done = (wait_r > {1'b0, delay_sel});

  // brake sequence
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: if (auto_r && enable_req) state_nxt = ST_PRE_REL;
      ST_PRE_REL: begin
        if (!auto_r || !enable_req) state_nxt = ST_STOP;
        else if (wait_done) state_nxt = ST_POST_REL;
      end
      ST_POST_REL: begin
        if (!auto_r || !enable_req) state_nxt = ST_STOP;
        else if (wait_done) state_nxt = ST_ENABLED;
      end
      ST_ENABLED: if (!auto_r || !enable_req) state_nxt = ST_STOP;
      ST_STOP: if (still_r) state_nxt = ST_PRE_ENG;
      ST_PRE_ENG: if (wait_done) state_nxt = ST_POST_ENG;
      ST_POST_ENG: if (wait_done) state_nxt = ST_OFF;
      default: state_nxt = ST_OFF;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_OFF;
      wait_r <= {(DELAY_W+1){1'b0}};
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        wait_r <= {(DELAY_W+1){1'b0}};
      else if (tick_r && !wait_done)
        wait_r <= wait_r + {{DELAY_W{1'b0}}, 1'b1};
    end
  end

  // pwm: 100 duty steps per period at freq*100 steps per second; period set by freq alone
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= 28'h0000000;
      step_r <= 7'h00;
      pwm_r <= 1'b0;
    end else begin
      if (acc_r + {7'h00, freq_r, 2'b00} * 28'd25 >= CLK_HZ_W) begin
        acc_r <= acc_r + {7'h00, freq_r, 2'b00} * 28'd25 - CLK_HZ_W;
        step_r <= (step_r == `DUTY_MAX - 7'h01) ? 7'h00 : step_r + 7'h01;
      end else begin
        acc_r <= acc_r + {7'h00, freq_r, 2'b00} * 28'd25;
      end
      pwm_r <= (duty_r == `DUTY_MAX) | (step_r < duty_r);
    end
  end

  // registered outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motor_current_on <= 1'b0;
      halt_req <= 1'b0;
      brake_out <= 1'b0;
      op_enabled <= 1'b0;
    end else if (!auto_r && state_r == ST_OFF) begin
      motor_current_on <= enable_req;
      halt_req <= 1'b0;
      brake_out <= manual_r;
      op_enabled <= enable_req;
    end else begin
      motor_current_on <= (state_r != ST_OFF);
      halt_req <= (state_r == ST_STOP) | (state_r == ST_PRE_ENG) | (state_r == ST_POST_ENG);
      // released only from release step until the engage step
      brake_out <= ((state_r == ST_POST_REL) | (state_r == ST_ENABLED) | (state_r == ST_STOP) |
                    (state_r == ST_PRE_ENG)) & pwm_r;
      op_enabled <= (state_r == ST_ENABLED);
    end
  end
endmodule
`default_nettype wire

// file: core/brake_sequencer_pwm_defs.vh
`ifndef BRAKE_SEQUENCER_PWM_DEFS_VH
`define BRAKE_SEQUENCER_PWM_DEFS_VH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_PRE_REL 8'h04
`define OFS_POST_REL 8'h08
`define OFS_PRE_ENG 8'h0C
`define OFS_POST_ENG 8'h10
`define OFS_PWM_FREQ 8'h14
`define OFS_PWM_DUTY 8'h18
`define OFS_STATUS 8'h1C
// ctrl fields
`define CTRL_AUTO_BIT 2
`define CTRL_MANUAL_BIT 0
// reset values
`define CTRL_RST 32'h0000_0004
`define DELAY_RST 16'h0000
`define FREQ_RST 11'h3E8
`define DUTY_RST 7'h64
// limits
`define FREQ_MAX 11'h7D0
`define DUTY_MIN 7'h02
`define DUTY_MAX 7'h64
// timing
`define CLK_HZ 100000000
`define DELAY_UNIT_US 1000
`define CLK_PERIOD_NS 10
`endif

// file: testbench/brake_sequencer_pwm_props.sv
`default_nettype none
module brake_sequencer_pwm_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic enable_req,
  input wire logic motor_current_on,
  input wire logic halt_req,
  input wire logic brake_out,
  input wire logic op_enabled
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // bus answers at once and always okay, from the second edge after reset
  chk_resp_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
  chk_ready_high: assert property ($past(hresetn) |-> hreadyout) else $error("wait state seen");
  chk_rdata_hold: assert property (!$past(hsel && hready && htrans[1]) |-> $stable(hrdata))
    else $error("read data moved without transfer");
  // enable from idle: current two edges later, brake still held
  chk_current_first: assert property ($rose(enable_req) && !motor_current_on && !halt_req |->
    ##2 (motor_current_on && !brake_out)) else $error("current not first");
  chk_enabled_on: assert property (op_enabled |-> motor_current_on && !halt_req)
    else $error("enabled without current");
  chk_stop_halt: assert property ($fell(op_enabled) |-> halt_req) else $error("no halt on leave");
  chk_halt_hold: assert property (halt_req && motor_current_on |=> halt_req || !motor_current_on)
    else $error("halt dropped early");
  chk_engage_first: assert property ($fell(motor_current_on) |-> !brake_out && !$past(brake_out))
    else $error("current off before brake");
endmodule
bind brake_sequencer_pwm brake_sequencer_pwm_props props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .enable_req(enable_req), .motor_current_on(motor_current_on), .halt_req(halt_req),
  .brake_out(brake_out), .op_enabled(op_enabled));
`default_nettype wire

// file: testbench/power_stage_model.sv
`default_nettype none
module power_stage_model #(parameter int STOP_CYCLES = 5) (
  input wire logic hclk,
  input wire logic motor_current_on,
  input wire logic halt_req,
  output logic standstill
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // the rotor coasts a few cycles once torque is withdrawn, so standstill lags the halt
  always @(posedge hclk) begin
    if (motor_current_on && !halt_req) cnt <= 0;
    else if (cnt < STOP_CYCLES) cnt <= cnt + 1;
  end
  assign standstill = (cnt == STOP_CYCLES);
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`include "brake_sequencer_pwm_defs.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 10;
  localparam int PER = 100000000 / 2000;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, enable_req = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, q;
  wire [31:0] hrdata;
  wire hreadyout, hresp, standstill, motor_current_on, halt_req, brake_out, op_enabled;
  wire hready = (hreadyout === 1'b1);
  wire [3:0] outs = {op_enabled, brake_out, halt_req, motor_current_on};
  int bad_count = 0, cmp_count = 0, cyc = 0;
  brake_sequencer_pwm #(.TICK_CYCLES(TICK), .DELAY_W(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .enable_req(enable_req), .standstill(standstill),
    .motor_current_on(motor_current_on), .halt_req(halt_req), .brake_out(brake_out), .op_enabled(op_enabled));
  power_stage_model ps (.hclk(hclk), .motor_current_on(motor_current_on), .halt_req(halt_req),
    .standstill(standstill));
  initial forever #5 hclk = ~hclk;
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard: about 1.3 slow pwm periods (near 65k cycles) dominate the run, ceiling leaves margin
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single word: address phase held until hready, then data phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(q, exp);
  endtask
  // edges until an output reaches a level; the count must land in the window
  task automatic wt(input int b, input logic v, input int lo, input int hi);
    int n = 0;
    while (outs[b] !== v && n <= hi) begin
      @(posedge hclk);
      n++;
    end
    check(32'(n), (n >= lo && n <= hi) ? 32'(n) : 32'(lo));
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`OFS_CTRL, `CTRL_RST);
    rd(`OFS_PRE_REL, 32'h0);
    rd(`OFS_PWM_DUTY, 32'h64);
    wr(8'h20, 32'h5);
    rd(8'h20, 32'h0);
    wr(`OFS_PWM_FREQ, 32'h7D1);
    rd(`OFS_PWM_FREQ, 32'h3E8);
    wr(`OFS_PWM_FREQ, 32'h7D0);
    rd(`OFS_PWM_FREQ, 32'h7D0);
    wr(`OFS_PWM_DUTY, 32'h01);
    wr(`OFS_PWM_DUTY, 32'h65);
    rd(`OFS_PWM_DUTY, 32'h64);
    wr(`OFS_PWM_DUTY, 32'h02);
    rd(`OFS_PWM_DUTY, 32'h02);
    wr(`OFS_PWM_DUTY, 32'h64);
    wr(`OFS_PRE_REL, 32'h2);
    wr(`OFS_POST_REL, 32'h3);
    wr(`OFS_PRE_ENG, 32'h1);
    wr(`OFS_POST_ENG, 32'h2);
    check(32'(outs), 32'h0);
    $display("test registers done");
    wr(`OFS_CTRL, 32'h1);
    wt(2, 1'b1, 0, 4);
    check(32'(outs), 32'h4);
    wr(`OFS_CTRL, 32'h0);
    wt(2, 1'b0, 0, 4);
    wr(`OFS_CTRL, 32'h4);
    $display("test manual done");
    enable_req <= 1'b1;
    wt(0, 1'b1, 3, 3);
    wt(2, 1'b1, 2 * TICK - 1, 3 * TICK + 3);
    wt(3, 1'b1, 3 * TICK - 1, 4 * TICK + 3);
    repeat (200) @(posedge hclk) check(32'(brake_out), 32'h1);
    // quarter duty at the top frequency: high time is a quarter of the period
    wr(`OFS_PWM_DUTY, 32'h19);
    wt(2, 1'b0, 0, PER);
    wt(2, 1'b1, 0, PER);
    wt(2, 1'b0, PER / 4 - 1, PER / 4 + 1);
    wr(`OFS_PWM_DUTY, 32'h64);
    wt(2, 1'b1, 0, PER);
    $display("test release done");
    enable_req <= 1'b0;
    wt(1, 1'b1, 1, 3);
    wt(2, 1'b0, TICK + 4, 2 * TICK + 12);
    wt(0, 1'b0, 2 * TICK - 1, 3 * TICK + 3);
    @(posedge hclk);
    check(32'(outs), 32'h0);
    $display("test engage done");
    // leave request while the pre-release wait is still running
    wr(`OFS_PRE_REL, 32'h5);
    enable_req <= 1'b1;
    wt(0, 1'b1, 3, 3);
    repeat (10) @(posedge hclk);
    enable_req <= 1'b0;
    wt(1, 1'b1, 1, 3);
    wt(0, 1'b0, 3 * TICK + 4, 5 * TICK + 12);
    @(posedge hclk);
    check(32'(outs), 32'h0);
    $display("test abort done");
    print_verdict();
  end
endmodule
`default_nettype wire
